// [core/adc_seq.sv]
// Acquisition and conversion sequencer of a 10-bit SAR converter.
// Assumes Avalon-MM master, synchronous inputs, SAR bits from analog side.
// Notes on behaviour
// - Programmed acquisition 2-20 periods, then convert
// - Code 010 gives four acquisition periods
// - Code 000 converts immediately on go
// - Acquisition select resets to manual 000
// - Completion clears go, sets done, resamples
// - No acquisition-ended or converting status exposed
// - Conversion lasts eleven bit periods
// - Clock select maps to oscillator divisions
// - Manual with RC clock adds instruction delay
// - Conversion ignores channel and direction bits
// - Analog pins read zero in port view
// - Strap chooses port B analog reset value
// - Clearing go aborts, result kept
// - Result holds last conversion or write
// - Two-period wait after finish, up to two after abort
// - Array discharged before every sample
// - Reset restores defaults, converter off
// - Completion loads result pair
`timescale 1ns/1ps
module adc_seq
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Analog side
  input  wire logic        rc_pulse_in,
  input  wire logic [9:0]  sar_result_in,
  input  wire logic [3:0]  port_pins_in,
  input  wire logic        portb_analog_at_reset_in,
  output logic             sample_out,
  output logic             discharge_out,
  output logic             convert_out,
  output logic [3:0]       channel_select_out
);
  // Registers
  logic        converter_on_ff;         // Module enable
  logic        go_ff;                   // Go flag
  logic [3:0]  channel_select_ff;       // Channel
  logic [3:0]  pin_analog_config_ff;    // 1 = digital pin
  logic [2:0]  acq_sel_ff;              // Acquisition time select
  logic [2:0]  clk_sel_ff;              // Conversion clock select
  logic [9:0]  result_pair_ff;          // Result pair
  logic        done_flag_ff;            // Conversion-done flag
  logic        strap_done_ff;           // Strap captured once
  logic        ack_ff;                  // Bus answer pending
  logic [31:0] rdata_ff;                // Read data
  adc_seq_pkg::seq_state_t state_ff;    // Sequencer state
  logic [4:0]  per_cnt_ff;              // Bit periods counted
  logic [7:0]  dly_cnt_ff;              // Core clocks of delay
  logic        sample_ff;               // Sample switch
  logic        disch_ff;                // Discharge switch
  logic        conv_ff;                 // Converting
  logic [3:0]  chan_ff;                 // Channel to analog side
  // Divider link
  bit_tick_if tk();
  bit_period_div u_div
  (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .rc_pulse_in (rc_pulse_in),
    .tk          (tk)
  );
  // Bus decode
  wire        req       = (avs_read_in | avs_write_in) & ~ack_ff;
  wire        wr_ack    = avs_write_in & ack_ff;  // Lands on answer edge
  wire        wr_ctl    = wr_ack & avs_address_in == adc_seq_pkg::OFF_CONTROL;
  wire        wr_tim    = wr_ack & avs_address_in == adc_seq_pkg::OFF_TIMING;
  wire        wr_res    = wr_ack & avs_address_in == adc_seq_pkg::OFF_RESULT;
  wire        wr_sta    = wr_ack & avs_address_in == adc_seq_pkg::OFF_STATUS;
  wire        wd_go     = avs_writedata_in[adc_seq_pkg::CTL_GO_BIT];
  wire        wd_on     = avs_writedata_in[adc_seq_pkg::CTL_ON_BIT];
  // Go may only start from sampling with the converter on
  wire        go_set    = wr_ctl & wd_go & ~go_ff & converter_on_ff & wd_on;
  wire        go_clr_sw = wr_ctl & ~wd_go & go_ff;
  wire        rc_sel    = (clk_sel_ff[1:0] == 2'b11);
  wire        active    = (state_ff == adc_seq_pkg::ST_ACQUIRE)
                        | (state_ff == adc_seq_pkg::ST_CONVERT)
                        | (state_ff == adc_seq_pkg::ST_DELAY);
  wire        abort     = active & (go_clr_sw | (wr_ctl & ~wd_on));
  wire        conv_end  = (state_ff == adc_seq_pkg::ST_CONVERT) & tk.tick
                        & (per_cnt_ff == adc_seq_pkg::CONV_PERIODS - 5'h01);
  wire [4:0]  acq_n     = adc_seq_pkg::acq_periods(acq_sel_ff);
  // Port view: analog pins read zero
  wire [3:0]  port_view = port_pins_in & pin_analog_config_ff;
  assign tk.run = (state_ff == adc_seq_pkg::ST_ACQUIRE)
                | (state_ff == adc_seq_pkg::ST_CONVERT)
                | (state_ff == adc_seq_pkg::ST_WAIT);
  assign tk.cs  = clk_sel_ff;
  // Read mux; no acquisition or converting status is visible
  wire [31:0] rd_mux =
    (avs_address_in == adc_seq_pkg::OFF_CONTROL) ?
      {20'h0_0000, pin_analog_config_ff, 2'b00, channel_select_ff,
       go_ff, converter_on_ff} :
    (avs_address_in == adc_seq_pkg::OFF_TIMING) ?
      {26'h000_0000, acq_sel_ff, clk_sel_ff} :
    (avs_address_in == adc_seq_pkg::OFF_RESULT) ?
      {22'h00_0000, result_pair_ff} :
    (avs_address_in == adc_seq_pkg::OFF_STATUS) ?
      {27'h000_0000, port_view, done_flag_ff} : 32'h0000_0000;
  assign avs_readdata_out    = rdata_ff;
  assign avs_waitrequest_out = ~ack_ff;
  assign sample_out          = sample_ff;
  assign discharge_out       = disch_ff;
  assign convert_out         = conv_ff;
  assign channel_select_out  = chan_ff;
  // Bus answer: one wait cycle, then acknowledge; unmapped reads zero
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff   <= req;
      rdata_ff <= req ? rd_mux : rdata_ff;
    end
  end
  // Control registers; reset turns the converter off
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      converter_on_ff   <= 1'b0;
      channel_select_ff <= 4'h0;
      acq_sel_ff        <= adc_seq_pkg::ACQ_RESET;
      clk_sel_ff        <= adc_seq_pkg::CS_RESET;
    end
    else if (wr_ctl)
    begin
      converter_on_ff   <= wd_on;
      channel_select_ff <= avs_writedata_in[adc_seq_pkg::CTL_CHS_LSB +: 4];
    end
    else if (wr_tim)
    begin
      clk_sel_ff <= avs_writedata_in[adc_seq_pkg::TIM_CS_LSB +: 3];
      acq_sel_ff <= avs_writedata_in[adc_seq_pkg::TIM_ACQ_LSB +: 3];
    end
  end
  // Pin config: strap taken after reset release, not at reset
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_analog_config_ff <= adc_seq_pkg::CFG_ANALOG;
      strap_done_ff        <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      strap_done_ff        <= 1'b1;
      pin_analog_config_ff <= portb_analog_at_reset_in ?
                              adc_seq_pkg::CFG_ANALOG :
                              adc_seq_pkg::CFG_DIGITAL;
    end
    else if (wr_ctl)
      pin_analog_config_ff <= avs_writedata_in[adc_seq_pkg::CTL_CFG_LSB +: 4];
  end
  // Go flag cleared by hardware at completion
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      go_ff <= 1'b0;
    else if (conv_end || abort || !converter_on_ff)
      go_ff <= go_set;
    else if (go_set)
      go_ff <= 1'b1;
  end
  // Done flag: set wins over software clear; write 1 clears
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      done_flag_ff <= 1'b0;
    else if (conv_end && !abort)
      done_flag_ff <= 1'b1;
    else if (wr_sta && avs_writedata_in[0])
      done_flag_ff <= 1'b0;
  end
  // Result pair: loaded on completion only, else software value
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      result_pair_ff <= 10'h000;
    else if (conv_end && !abort)
      result_pair_ff <= sar_result_in;
    else if (wr_res)
      result_pair_ff <= avs_writedata_in[9:0];
  end
  // Sequencer state and period counters
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff   <= adc_seq_pkg::ST_OFF;
      per_cnt_ff <= 5'h00;
      dly_cnt_ff <= 8'h00;
    end
    else if (!converter_on_ff)
      state_ff <= adc_seq_pkg::ST_OFF;
    else if (abort)  // Abort still waits up to two periods
    begin
      state_ff   <= adc_seq_pkg::ST_WAIT;
      per_cnt_ff <= 5'h00;
    end
    else
    begin
      unique case (state_ff)
        adc_seq_pkg::ST_OFF:
          state_ff <= adc_seq_pkg::ST_DISCH;
        adc_seq_pkg::ST_DISCH:
          // Array discharged for one clock before sampling
          state_ff <= adc_seq_pkg::ST_SAMPLE;
        adc_seq_pkg::ST_SAMPLE:
          if (go_ff)
          begin
            per_cnt_ff <= 5'h00;
            dly_cnt_ff <= 8'h00;
            if (acq_n != 5'h00)
              state_ff <= adc_seq_pkg::ST_ACQUIRE;
            else if (rc_sel)
              state_ff <= adc_seq_pkg::ST_DELAY;
            else
              state_ff <= adc_seq_pkg::ST_CONVERT;
          end
        adc_seq_pkg::ST_DELAY:
          if (dly_cnt_ff == adc_seq_pkg::TCY_CYCLES - 8'h01)
            state_ff <= adc_seq_pkg::ST_CONVERT;
          else
            dly_cnt_ff <= dly_cnt_ff + 8'h01;
        adc_seq_pkg::ST_ACQUIRE:
          if (tk.tick)
          begin
            if (per_cnt_ff == acq_n - 5'h01)
            begin
              per_cnt_ff <= 5'h00;
              state_ff   <= adc_seq_pkg::ST_CONVERT;
            end
            else
              per_cnt_ff <= per_cnt_ff + 5'h01;
          end
        adc_seq_pkg::ST_CONVERT:
          // Eleven periods, regardless of channel or pin direction
          if (conv_end)
          begin
            per_cnt_ff <= 5'h00;
            state_ff   <= adc_seq_pkg::ST_WAIT;
          end
          else if (tk.tick)
            per_cnt_ff <= per_cnt_ff + 5'h01;
        adc_seq_pkg::ST_WAIT:
          if (tk.tick)
          begin
            if (per_cnt_ff == adc_seq_pkg::WAIT_PERIODS - 5'h01)
              state_ff <= adc_seq_pkg::ST_DISCH;
            else
              per_cnt_ff <= per_cnt_ff + 5'h01;
          end
      endcase
    end
  end
  // Analog switch drives, registered
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sample_ff <= 1'b0;
      disch_ff  <= 1'b0;
      conv_ff   <= 1'b0;
      chan_ff   <= 4'h0;
    end
    else
    begin
      sample_ff <= (state_ff == adc_seq_pkg::ST_SAMPLE)
                 | (state_ff == adc_seq_pkg::ST_ACQUIRE);
      disch_ff  <= (state_ff == adc_seq_pkg::ST_DISCH);
      conv_ff   <= (state_ff == adc_seq_pkg::ST_CONVERT);
      chan_ff   <= channel_select_ff;
    end
  end
  // Checks
  property p_conv_len;
    @(posedge core_clk_in) disable iff (rst_in)
    $rose(state_ff == adc_seq_pkg::ST_CONVERT)
    |-> per_cnt_ff == 5'h00;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length");
  property p_done_set;
    @(posedge core_clk_in) disable iff (rst_in)
    (conv_end && !abort) |=> done_flag_ff && !go_ff;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set");
  property p_result;
    @(posedge core_clk_in) disable iff (rst_in)
    (conv_end && !abort) |=> result_pair_ff == $past(sar_result_in);
  endproperty
  a_result: assert property (p_result) else $error("result not loaded");
  property p_hold;
    @(posedge core_clk_in) disable iff (rst_in)
    (!conv_end && !wr_res) |=> $stable(result_pair_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed");
  property p_wait;
    @(posedge core_clk_in) disable iff (rst_in)
    (abort && converter_on_ff) |=> state_ff == adc_seq_pkg::ST_WAIT;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait after abort");
  property p_manual;
    @(posedge core_clk_in) disable iff (rst_in)
    (state_ff == adc_seq_pkg::ST_SAMPLE && go_ff && converter_on_ff
     && !abort && acq_sel_ff == 3'h0 && !rc_sel)
    |=> state_ff == adc_seq_pkg::ST_CONVERT;
  endproperty
  a_manual: assert property (p_manual) else $error("manual start late");
  property p_off;
    @(posedge core_clk_in) disable iff (rst_in)
    !converter_on_ff |=> !go_ff || converter_on_ff;
  endproperty
  a_off: assert property (p_off) else $error("go set while off");
  property p_disch;
    @(posedge core_clk_in) disable iff (rst_in)
    $rose(sample_ff) |-> $past(disch_ff);
  endproperty
  a_disch: assert property (p_disch) else $error("sample w/o discharge");
endmodule

// [core/adc_seq_pkg.sv]
// Constants shared by the conversion sequencer and its bit-period divider.
// Assumes a single 125 MHz core clock and an Avalon-MM register bus.
package adc_seq_pkg;
  // Register word offsets (byte addresses)
  localparam logic [3:0] OFF_CONTROL   = 4'h0;  // Go, on, channel
  localparam logic [3:0] OFF_TIMING    = 4'h4;  // Acquisition/clock select
  localparam logic [3:0] OFF_RESULT    = 4'h8;  // Result pair
  localparam logic [3:0] OFF_STATUS    = 4'hC;  // Done flag, port view
  // Control field positions
  localparam int CTL_ON_BIT            = 0;
  localparam int CTL_GO_BIT            = 1;
  localparam int CTL_CHS_LSB           = 2;
  localparam int CTL_CFG_LSB           = 8;
  // Timing field positions
  localparam int TIM_CS_LSB            = 0;
  localparam int TIM_ACQ_LSB           = 3;
  // Reset values
  localparam logic [2:0] ACQ_RESET     = 3'h0;
  localparam logic [2:0] CS_RESET      = 3'h0;
  localparam logic [3:0] CFG_ANALOG    = 4'h0;
  localparam logic [3:0] CFG_DIGITAL   = 4'hF;
  // Timing counts in bit periods
  localparam logic [4:0] CONV_PERIODS  = 5'h0B;
  localparam logic [4:0] WAIT_PERIODS  = 5'h02;
  // One instruction cycle, in core clocks, for the sleep-entry delay
  localparam int TCY_NS                = 32;
  localparam int CLK_NS                = 8;
  localparam logic [7:0] TCY_CYCLES    = 8'((TCY_NS + CLK_NS - 1) / CLK_NS);
  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_SAMPLE, ST_DELAY, ST_ACQUIRE, ST_CONVERT, ST_WAIT, ST_DISCH
  } seq_state_t;
  // Acquisition periods by code
  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    unique case (code)
      3'h0: acq_periods = 5'h00;
      3'h1: acq_periods = 5'h02;
      3'h2: acq_periods = 5'h04;
      3'h3: acq_periods = 5'h06;
      3'h4: acq_periods = 5'h08;
      3'h5: acq_periods = 5'h0C;
      3'h6: acq_periods = 5'h10;
      3'h7: acq_periods = 5'h14;
    endcase
  endfunction
  // Half bit period in core clocks (toggle count), for oscillator sources
  function automatic logic [5:0] half_div(input logic [2:0] code);
    unique case (code)
      3'h0: half_div = 6'h01;
      3'h4: half_div = 6'h02;
      3'h1: half_div = 6'h04;
      3'h5: half_div = 6'h08;
      3'h2: half_div = 6'h10;
      3'h6: half_div = 6'h20;
      default: half_div = 6'h01;
    endcase
  endfunction
endpackage

// [core/bit_tick_if.sv]
// Carries the bit-period tick between the divider and the sequencer.
// Assumes both ends share core_clk_in.
`timescale 1ns/1ps
interface bit_tick_if;
  logic       run;      // Divider enabled
  logic [2:0] cs;       // Conversion clock select
  logic       tick;     // One-cycle bit-period pulse
  modport src (input run, input cs, output tick);
  modport dst (output run, output cs, input tick);
endinterface

// [core/bit_period_div.sv]
// Bit-period divider: one-cycle tick per bit period.
// Assumes RC clock edges arrive as a synchronous one-cycle pulse.
`timescale 1ns/1ps
module bit_period_div
(
  // Clock and reset
  input  wire logic   core_clk_in,
  input  wire logic   rst_in,
  // Internal RC clock pulse
  input  wire logic   rc_pulse_in,
  // Tick link
  bit_tick_if.src     tk
);
  logic [6:0] cnt_ff;    // Oscillator periods in this bit period
  logic       tick_ff;   // Registered tick
  wire        rc_sel   = (tk.cs[1:0] == 2'b11);
  wire  [6:0] full_cnt = {adc_seq_pkg::half_div(tk.cs), 1'b0};
  wire        osc_end  = (cnt_ff >= full_cnt - 7'h01);
  wire        nxt_tick = tk.run & (rc_sel ? rc_pulse_in : osc_end);
  assign tk.tick = tick_ff;
  // Divider counter, held clear while idle
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= (!tk.run || rc_sel || osc_end) ? 7'h00 : cnt_ff + 7'h01;
      tick_ff <= nxt_tick;
    end
  end
endmodule

// [verification/analog_side_model.sv]
// Far-side model: RC bit-period pulse source and the SAR array result.
// Assumes the sequencer samples the result while convert is high.
`timescale 1ns/1ps
module analog_side_model
#(
  parameter int RC_DIV = 10            // Core clocks per RC bit period
)
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // Sequencer side
  input  wire logic       convert_in,
  input  wire logic [9:0] value_in,
  output logic            rc_pulse_out,
  output logic [9:0]      sar_result_out
);
  logic [7:0] cnt_ff;                  // RC period counter
  logic [7:0] nxt_cnt;
  logic       wrap;                    // Last clock of an RC period
  assign wrap    = (cnt_ff == 8'(RC_DIV - 1));
  assign nxt_cnt = wrap ? 8'h00 : cnt_ff + 8'h01;
  // Array output is only meaningful while converting; else show junk
  assign sar_result_out = convert_in ? value_in : ~value_in;
  // RC oscillator runs free, so the pulse never stops
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_ff       <= 8'h00;
      rc_pulse_out <= 1'b0;
    end
    else
    begin
      cnt_ff       <= nxt_cnt;
      rc_pulse_out <= wrap;
    end
  end
endmodule

// [verification/test_adc_acquisition_conversion_sequencer.sv]
// Self-checking bench for the acquisition and conversion sequencer.
// Assumes the analog side model; registers over Avalon-MM.
`timescale 1ns/1ps
module test_adc_acquisition_conversion_sequencer;
  localparam int RC_DIV = 10;          // Bench RC period, in clocks
  // Clock, reset and bus
  logic        clk;
  logic        rst;
  logic [3:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_rq;
  // Analog side
  logic        rc_pulse;
  logic [9:0]  sar;
  logic [3:0]  pins;
  logic        strap;
  logic        smp;
  logic        dis;
  logic        cnv;
  logic [3:0]  chan;
  logic [9:0]  value;
  logic [9:0]  last;                   // Expected result pair
  logic [3:0]  ch;
  logic [31:0] q;
  // Bookkeeping: cycle stamps of output edges
  int          n_mismatch, checked, cyc, take, t_on, t_off, t_smp, t_dis;
  logic        prev_cnv, prev_smp;

  adc_seq u_adc_seq (.core_clk_in(clk), .rst_in(rst), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
    .rc_pulse_in(rc_pulse), .sar_result_in(sar), .port_pins_in(pins),
    .portb_analog_at_reset_in(strap), .sample_out(smp),
    .discharge_out(dis), .convert_out(cnv), .channel_select_out(chan));
  analog_side_model #(.RC_DIV(RC_DIV)) u_analog_side_model (
    .core_clk_in(clk), .rst_in(rst), .convert_in(cnv), .value_in(value),
    .rc_pulse_out(rc_pulse), .sar_result_out(sar));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Edge stamps; NBA keeps cyc coherent with the bus tasks
  always @(posedge clk)
  begin
    cyc      <= cyc + 1;
    prev_cnv <= cnv;
    prev_smp <= smp;
    if (cnv && !prev_cnv) t_on <= cyc;
    if (!cnv && prev_cnv) t_off <= cyc;
    if (smp && !prev_smp) t_smp <= cyc;
    if (dis) t_dis <= cyc;
  end
  // Compare; slack widens an exact figure to a timing window
  task automatic check(input string what, input logic [31:0] seen, exp,
                       input int slack = 0);
    begin
      checked++;
      if ($isunknown(seen) || (slack == 0 ? seen != exp :
          (int'(seen) < int'(exp) - slack || int'(seen) > int'(exp) + slack)))
      begin
        n_mismatch++;
        $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task automatic end_of_test();
    begin
      if (n_mismatch == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] rq);
    int n;
    begin
      @(posedge clk);
      adr   <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (wait_rq !== 1'b0 && n < 100);
      rq   = rdata;
      take = cyc;
      rd  <= 1'b0;
      wr  <= 1'b0;
      if (n >= 100) check("bus answer", 0, 1);
    end
  endtask
  function automatic logic [31:0] ctl(logic on, go, logic [3:0] c, cfg);
    ctl = 32'(on) << adc_seq_pkg::CTL_ON_BIT
        | 32'(go) << adc_seq_pkg::CTL_GO_BIT
        | 32'(c) << adc_seq_pkg::CTL_CHS_LSB
        | 32'(cfg) << adc_seq_pkg::CTL_CFG_LSB;
  endfunction
  // Bit period in clocks and acquisition periods by code
  function automatic int div_of(logic [2:0] cs);
    case (cs)
      3'h0: div_of = 2;
      3'h4: div_of = 4;
      3'h1: div_of = 8;
      3'h5: div_of = 16;
      3'h2: div_of = 32;
      3'h6: div_of = 64;
      default: div_of = RC_DIV;
    endcase
  endfunction
  function automatic int acq_of(logic [2:0] a);
    int t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    acq_of = t[a];
  endfunction
  // One go; the converter must already be on and sampling
  task automatic run(input logic [2:0] cs, acq, input logic abort);
    int d, lo, hi, go_t, n, e, s;
    begin
      d  = div_of(cs);  // Bit period in clocks
      lo = acq_of(acq) * d - d;
      hi = lo + 2 * d + 3;
      if (acq == 3'h0)
      begin
        lo = (cs[1:0] == 2'b11) ? 4 : 0;
        hi = lo + 3;  // Now, or up to three cycles late
      end
      value = 10'($urandom);
      ch    = 4'($urandom);
      bus(1'b1, adc_seq_pkg::OFF_TIMING, 32'(acq) << 3 | 32'(cs), q);
      bus(1'b1, adc_seq_pkg::OFF_CONTROL, ctl(1'b1, 1'b1, ch, 4'hF), q);
      go_t = take;
      if (hi > 40)
      begin
        bus(1'b0, adc_seq_pkg::OFF_CONTROL, 32'h0000_0000, q);
        check("go busy", q[adc_seq_pkg::CTL_GO_BIT], 1);
        bus(1'b0, adc_seq_pkg::OFF_STATUS, 32'h0000_0000, q);
        check("done busy", q[0], 0);
      end
      n = 0;
      while (t_on <= go_t && n < 9000)
      begin
        @(posedge clk);
        n++;
      end
      e = (lo + hi) / 2;
      s = (hi - lo + 1) / 2;
      check("start delay", t_on - go_t, e, s);
      if (abort)
      begin
        repeat (30) @(posedge clk);
        bus(1'b1, adc_seq_pkg::OFF_CONTROL, ctl(1'b1, 1'b0, ch, 4'hF), q);
      end
      else
        last = value;
      while ((t_off <= t_on || t_smp <= t_off) && n < 9000)
      begin
        @(posedge clk);
        n++;
      end
      if (n >= 9000) check("progress", 0, 1);
      if (!abort)
        check("conv length", t_off - t_on, 11 * d, d);
      // An abort cuts the running period, so its wait may be shorter
      lo = abort ? d + 2 : 2 * d + 1;
      hi = 2 * d + 1;
      e  = (lo + hi) / 2;
      s  = (hi - lo + 1) / 2;
      check("wait", t_smp - t_off, e, s);
      check("discharge", t_dis > t_off && t_dis < t_smp, 1);
      check("channel", chan, ch);
      bus(1'b0, adc_seq_pkg::OFF_CONTROL, 32'h0000_0000, q);
      check("go cleared", q[adc_seq_pkg::CTL_GO_BIT], 0);
      bus(1'b0, adc_seq_pkg::OFF_STATUS, 32'h0000_0000, q);
      check("done", q[0], !abort);
      bus(1'b0, adc_seq_pkg::OFF_RESULT, 32'h0000_0000, q);
      check("result", q[9:0], last);
      bus(1'b1, adc_seq_pkg::OFF_STATUS, 32'h0000_0001, q);
    end
  endtask
  // Hang guard, well past the longest expected run
  initial
  begin
    #480000;
    n_mismatch++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    {adr, rd, wr, wdata, pins, value, last, ch} = '0;
    {n_mismatch, checked, cyc, take, t_on, t_off, t_smp, t_dis} = '0;
    {strap, prev_cnv, prev_smp} = '0;
    rst = 1'b1;
    void'($urandom(32'h3cd7));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, adc_seq_pkg::OFF_CONTROL, 32'h0000_0000, q);
    check("control reset", q, 32'h0000_0F00);
    bus(1'b0, adc_seq_pkg::OFF_TIMING, 32'h0000_0000, q);
    check("timing reset", q, 32'h0000_0000);
    // Port view with random pins and pin config; go while off
    pins <= 4'($urandom);
    ch = 4'($urandom);
    bus(1'b1, adc_seq_pkg::OFF_CONTROL, ctl(1'b0, 1'b1, 4'h0, ch), q);
    bus(1'b0, adc_seq_pkg::OFF_STATUS, 32'h0000_0000, q);
    check("port view", q[4:0], {pins & ch, 1'b0});
    repeat (60) @(posedge clk);
    check("no start while off", t_on, 0);
    // Switch on in its own write, then sample
    bus(1'b1, adc_seq_pkg::OFF_CONTROL, ctl(1'b1, 1'b0, 4'h0, 4'hF), q);
    repeat (10) @(posedge clk);  // Go only in a later write
    for (int a = 0; a < 8; a++) run(3'h4, 3'(a), 1'b0);
    // RC manual starts stand for sleep entry, idle select already clear
    foreach (ch[i]) run(3'(i * 4 + 3), 3'h0, 1'b0);
    for (int c = 0; c < 8; c++) run(3'(c), 3'h0, 1'b0);
    last = 10'h2A5;
    bus(1'b1, adc_seq_pkg::OFF_RESULT, 32'h0000_02A5, q);
    run(3'h5, 3'h0, 1'b1);
    run(3'h3, 3'h2, 1'b1);
    repeat (4) run(3'($urandom), 3'($urandom), 1'b0);
    // Reset mid-conversion with the strap now analog
    strap <= 1'b1;
    bus(1'b1, adc_seq_pkg::OFF_CONTROL, ctl(1'b1, 1'b1, 4'h0, 4'hF), q);
    repeat (20) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("convert after reset", cnv, 0);
    check("sample after reset", smp, 0);
    bus(1'b0, adc_seq_pkg::OFF_CONTROL, 32'h0000_0000, q);
    check("control strap", q, 32'h0000_0000);
    end_of_test();
  end
endmodule
